// [rtw_alarm_match.sv]
`timescale 1ns/1ps
module rtw_alarm_match
  import rtw_pkg::*;
(
  input  wire logic [3:0] mask,
  input  wire rtw_time_s  tm,
  input  wire rtw_alarm_s al,
  input  wire logic       half_tick,
  input  wire logic       sec_tick,
  output logic            hit
);

  logic s1;
  logic s2;
  logic m1;
  logic m2;
  logic h2;

  always_comb begin
    s1 = (tm.seconds.lo == al.seconds.lo);
    s2 = s1 && (tm.seconds.hi == al.seconds.hi);
    m1 = s2 && (tm.minutes.lo == al.minutes.lo);
    m2 = m1 && (tm.minutes.hi == al.minutes.hi);
    h2 = m2 && (tm.hours == al.hours);
    hit = 1'b0;
    unique case (mask)
      MASK_HALF:  hit = half_tick;
      MASK_SEC:   hit = sec_tick;
      MASK_10SEC: hit = sec_tick && s1;
      MASK_MIN:   hit = sec_tick && s2;
      MASK_10MIN: hit = sec_tick && m1;
      MASK_HOUR:  hit = sec_tick && m2;
      MASK_DAY:   hit = sec_tick && h2;
      MASK_WEEK:  hit = sec_tick && h2 && (tm.weekday == al.weekday);
      MASK_MONTH: hit = sec_tick && h2 && (tm.day == al.day);
      MASK_YEAR:  hit = sec_tick && h2 && (tm.day == al.day) && (tm.month == al.month);
      default:    hit = 1'b0;
    endcase
  end

endmodule

// [rtw_core.sv]
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module rtw_core
  import rtw_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        dev_rst,
  input  wire logic        osc_pin,
  output logic             clk_out,
  output logic             clk_out_oe,
  output logic             alarm_flag,
  output logic             wake
);

  rtw_core_s    state_ff;
  rtw_core_s    nxt_state;
  logic         addr_go;
  logic         osc_tick;
  logic         presc_clear;
  logic         half_tick;
  logic         sec_tick;
  logic         half_bit;
  logic         near_roll;
  logic         hit;
  logic         evt;
  logic         armed_now;
  logic [7:0]   wd;
  rtw_clk_cfg_s wcfg;
  rtw_clk_cfg_s rcfg;
  rtw_al_cfg_s  wal;
  rtw_pad_s     wpad;
  rtw_pad_s     rpad;
  logic [31:0]  rd;

  // Clock counts whatever the power state; only the run bit of the clock config can hold it
  assign osc_tick = state_ff.osc_s2 && !state_ff.osc_prev && state_ff.run_en;

  rtw_prescaler u_presc (
    .hclk      (hclk),
    .osc_tick  (osc_tick),
    .clear     (presc_clear),
    .cal       (state_ff.cal),
    .half_tick (half_tick),
    .sec_tick  (sec_tick),
    .half_bit  (half_bit),
    .near_roll (near_roll)
  );

  rtw_alarm_match u_match (
    .mask      (state_ff.al_cfg.mask),
    .tm        (state_ff.tm),
    .al        (state_ff.al),
    .half_tick (half_tick),
    .sec_tick  (sec_tick),
    .hit       (hit)
  );

  assign evt = state_ff.al_cfg.en && hit;
  assign addr_go = hsel && htrans[HTRANS_ACT] && hready;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.osc_s1 = osc_pin;
    nxt_state.osc_s2 = state_ff.osc_s1;
    nxt_state.osc_prev = state_ff.osc_s2;
    nxt_state.wake = 1'b0;
    presc_clear = 1'b0;
    armed_now = 1'b0;
    wd = hwdata[7:0];
    wcfg = rtw_clk_cfg_s'(hwdata[7:0]);
    wal = rtw_al_cfg_s'(hwdata[7:0]);
    wpad = rtw_pad_s'(hwdata[7:0]);
    rcfg = '0;
    rpad = '0;
    rd = '0;

    // Data phase: the unlock arm lives for exactly one following transfer
    if (state_ff.dp_valid) begin
      armed_now = state_ff.armed;
      nxt_state.armed = 1'b0;
    end
    if (state_ff.dp_valid && state_ff.dp_write) begin
      nxt_state.key1 = 1'b0;
      unique case (state_ff.dp_addr)
        OFS_CLK_CFG: begin
          if (state_ff.wr_en) begin
            nxt_state.run_en = wcfg.run;
          end
          nxt_state.wr_en = wcfg.wren && (state_ff.wr_en || armed_now);
          nxt_state.out_en = wcfg.oe;
          nxt_state.tptr = wcfg.ptr;
        end
        OFS_CAL: begin
          nxt_state.cal = wd;
        end
        OFS_PAD_CFG: begin
          nxt_state.out_sel = wpad.sel;
        end
        OFS_AL_CFG: begin
          nxt_state.al_cfg = wal;
        end
        OFS_AL_RPT: begin
          nxt_state.al_rpt = wd;
        end
        OFS_TWIN_HI: begin
          if (state_ff.wr_en) begin
            unique case (state_ff.tptr)
              PTR_MINSEC: nxt_state.tm.minutes = wd;
              PTR_WDHR:   nxt_state.tm.weekday = wd;
              PTR_MONDAY: nxt_state.tm.month = wd;
              PTR_YEAR:   nxt_state.tm.month = state_ff.tm.month;
            endcase
          end
          nxt_state.tptr = dec_ptr(state_ff.tptr);
        end
        OFS_TWIN_LO: begin
          if (state_ff.wr_en) begin
            unique case (state_ff.tptr)
              PTR_MINSEC: begin
                nxt_state.tm.seconds = wd;
                presc_clear = 1'b1;
              end
              PTR_WDHR:   nxt_state.tm.hours = wd;
              PTR_MONDAY: nxt_state.tm.day = wd;
              PTR_YEAR:   nxt_state.tm.year = wd;
            endcase
          end
        end
        OFS_AWIN_HI: begin
          unique case (state_ff.al_cfg.ptr)
            PTR_MINSEC: nxt_state.al.minutes = wd;
            PTR_WDHR:   nxt_state.al.weekday = wd;
            PTR_MONDAY: nxt_state.al.month = wd;
            PTR_YEAR:   nxt_state.al.month = state_ff.al.month;
          endcase
          nxt_state.al_cfg.ptr = dec_ptr(state_ff.al_cfg.ptr);
        end
        OFS_AWIN_LO: begin
          unique case (state_ff.al_cfg.ptr)
            PTR_MINSEC: nxt_state.al.seconds = wd;
            PTR_WDHR:   nxt_state.al.hours = wd;
            PTR_MONDAY: nxt_state.al.day = wd;
            PTR_YEAR:   nxt_state.al.day = state_ff.al.day;
          endcase
        end
        OFS_UNLOCK: begin
          nxt_state.key1 = (wd == KEY_FIRST);
          nxt_state.armed = state_ff.key1 && (wd == KEY_SECOND);
        end
        OFS_STATUS: begin
          if (wd[STAT_FLAG]) begin
            nxt_state.al_flag = 1'b0;
          end
        end
        default: begin
          nxt_state.key1 = 1'b0;
        end
      endcase
    end

    // Address phase; reads see the data phase write just above
    nxt_state.dp_valid = addr_go;
    nxt_state.dp_write = addr_go && hwrite;
    nxt_state.dp_addr = haddr[7:0];
    if (addr_go && !hwrite) begin
      rcfg = '{run: nxt_state.run_en, rsvd: 1'b0, wren: nxt_state.wr_en,
               sync: near_roll, half: half_bit, oe: nxt_state.out_en,
               ptr: nxt_state.tptr};
      rpad.sel = nxt_state.out_sel;
      unique case (haddr[7:0])
        OFS_CLK_CFG: rd = word(rcfg);
        OFS_CAL:     rd = word(nxt_state.cal);
        OFS_PAD_CFG: rd = word(rpad);
        OFS_AL_CFG:  rd = word(nxt_state.al_cfg);
        OFS_AL_RPT:  rd = word(nxt_state.al_rpt);
        OFS_TWIN_HI: begin
          unique case (nxt_state.tptr)
            PTR_MINSEC: rd = word(nxt_state.tm.minutes);
            PTR_WDHR:   rd = word(nxt_state.tm.weekday);
            PTR_MONDAY: rd = word(nxt_state.tm.month);
            PTR_YEAR:   rd = '0;
          endcase
          nxt_state.tptr = dec_ptr(nxt_state.tptr);
        end
        OFS_TWIN_LO: begin
          unique case (nxt_state.tptr)
            PTR_MINSEC: rd = word(nxt_state.tm.seconds);
            PTR_WDHR:   rd = word(nxt_state.tm.hours);
            PTR_MONDAY: rd = word(nxt_state.tm.day);
            PTR_YEAR:   rd = word(nxt_state.tm.year);
          endcase
        end
        OFS_AWIN_HI: begin
          unique case (nxt_state.al_cfg.ptr)
            PTR_MINSEC: rd = word(nxt_state.al.minutes);
            PTR_WDHR:   rd = word(nxt_state.al.weekday);
            PTR_MONDAY: rd = word(nxt_state.al.month);
            PTR_YEAR:   rd = '0;
          endcase
          nxt_state.al_cfg.ptr = dec_ptr(nxt_state.al_cfg.ptr);
        end
        OFS_AWIN_LO: begin
          unique case (nxt_state.al_cfg.ptr)
            PTR_MINSEC: rd = word(nxt_state.al.seconds);
            PTR_WDHR:   rd = word(nxt_state.al.hours);
            PTR_MONDAY: rd = word(nxt_state.al.day);
            PTR_YEAR:   rd = '0;
          endcase
        end
        OFS_STATUS: rd = word({7'h00, nxt_state.al_flag});
        default:    rd = '0;
      endcase
      nxt_state.rdata = rd;
    end

    // Alarm handled after the bus so an event beats a same-cycle clear
    if (evt) begin
      nxt_state.al_flag = 1'b1;
      nxt_state.al_pulse = !state_ff.al_pulse;
      nxt_state.wake = 1'b1;
      if (state_ff.al_rpt != '0) begin
        nxt_state.al_rpt = 8'(state_ff.al_rpt - 8'h01);
      end else if (state_ff.al_cfg.endless_repeat) begin
        nxt_state.al_rpt = REPEAT_WRAP;
      end else begin
        nxt_state.al_cfg.en = 1'b0;
      end
    end

    unique case (state_ff.out_sel)
      SEL_ALARM: nxt_state.pin = state_ff.al_pulse;
      SEL_SEC:   nxt_state.pin = half_bit;
      default:   nxt_state.pin = 1'b0;
    endcase

    // Device reset touches alarm setup only; time and repeat keep going
    if (dev_rst) begin
      nxt_state.al_cfg = AL_CFG_RST;
    end
  end

  // Asynchronous reset is the power-on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= CORE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = state_ff.rdata;
  assign clk_out    = state_ff.pin;
  assign clk_out_oe = state_ff.out_en;
  assign alarm_flag = state_ff.al_flag;
  assign wake       = state_ff.wake;

endmodule

// [rtw_core_sva.sv]
`timescale 1ns/1ps
module rtw_core_sva
  import rtw_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        dev_rst,
  input wire logic        osc_pin,
  input wire logic        clk_out,
  input wire logic        clk_out_oe,
  input wire logic        alarm_flag,
  input wire logic        wake
);
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
  } rtw_sva_s;
  rtw_sva_s st_ff;
  rtw_sva_s nxt_st;
  // Keeps the address phase so write data in the data phase can be tied to it
  always_comb begin
    nxt_st.wr   = hsel && htrans[HTRANS_ACT] && hready && hwrite;
    nxt_st.addr = haddr[7:0];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  read_hold_a: assert property (!(hsel && htrans[HTRANS_ACT] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (hsel && htrans[HTRANS_ACT] && hready && !hwrite
    && haddr[7:0] > OFS_STATUS |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  oe_follow_a: assert property (st_ff.wr && st_ff.addr == OFS_CLK_CFG |=> clk_out_oe == $past(hwdata[2]))
    else $error("output enable not taken from config write");
  oe_change_a: assert property ($changed(clk_out_oe) |-> $past(st_ff.wr && st_ff.addr == OFS_CLK_CFG))
    else $error("output enable changed without config write");
  wake_pulse_a: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  flag_wake_a: assert property ($rose(alarm_flag) |-> ##[0:1] wake)
    else $error("alarm flag set without wake");
  flag_clear_a: assert property ($fell(alarm_flag) |->
    $past(st_ff.wr && st_ff.addr == OFS_STATUS && hwdata[STAT_FLAG]))
    else $error("alarm flag cleared without write of one");
  reset_quiet_a: assert property (dev_rst [*4] |-> !wake && !$rose(alarm_flag))
    else $error("alarm fired during device reset");
endmodule

bind rtw_core rtw_core_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dev_rst(dev_rst),
  .osc_pin(osc_pin), .clk_out(clk_out), .clk_out_oe(clk_out_oe),
  .alarm_flag(alarm_flag), .wake(wake)
);

// [rtw_pkg.sv]
package rtw_pkg;

  localparam logic [7:0] OFS_CLK_CFG  = 8'h00;
  localparam logic [7:0] OFS_CAL      = 8'h04;
  localparam logic [7:0] OFS_PAD_CFG  = 8'h08;
  localparam logic [7:0] OFS_AL_CFG   = 8'h0C;
  localparam logic [7:0] OFS_AL_RPT   = 8'h10;
  localparam logic [7:0] OFS_TWIN_HI  = 8'h14;
  localparam logic [7:0] OFS_TWIN_LO  = 8'h18;
  localparam logic [7:0] OFS_AWIN_HI  = 8'h1C;
  localparam logic [7:0] OFS_AWIN_LO  = 8'h20;
  localparam logic [7:0] OFS_UNLOCK   = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;

  localparam int HTRANS_ACT = 1;
  localparam int STAT_FLAG  = 0;

  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'hAA;
  localparam logic [7:0] REPEAT_WRAP = 8'hFF;

  localparam logic [1:0] PTR_MINSEC = 2'h0;
  localparam logic [1:0] PTR_WDHR   = 2'h1;
  localparam logic [1:0] PTR_MONDAY = 2'h2;
  localparam logic [1:0] PTR_YEAR   = 2'h3;

  localparam logic [3:0] MASK_HALF  = 4'h0;
  localparam logic [3:0] MASK_SEC   = 4'h1;
  localparam logic [3:0] MASK_10SEC = 4'h2;
  localparam logic [3:0] MASK_MIN   = 4'h3;
  localparam logic [3:0] MASK_10MIN = 4'h4;
  localparam logic [3:0] MASK_HOUR  = 4'h5;
  localparam logic [3:0] MASK_DAY   = 4'h6;
  localparam logic [3:0] MASK_WEEK  = 4'h7;
  localparam logic [3:0] MASK_MONTH = 4'h8;
  localparam logic [3:0] MASK_YEAR  = 4'h9;

  localparam logic [1:0] SEL_ALARM = 2'h0;
  localparam logic [1:0] SEL_SEC   = 2'h1;

  localparam logic signed [16:0] PRESC_LAST = 17'sh07FFF;
  localparam logic signed [16:0] HALF_LAST  = 17'sh03FFF;
  localparam logic signed [16:0] HALF_START = 17'sh04000;
  localparam logic signed [16:0] SYNC_START = 17'sh07FE0;
  localparam logic signed [16:0] PRESC_STEP = 17'sh00001;
  localparam logic [5:0]         SEC_LAST   = 6'h3B;
  localparam logic [5:0]         SEC_STEP   = 6'h01;

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } rtw_bcd_s;

  typedef struct packed {
    rtw_bcd_s year;
    rtw_bcd_s month;
    rtw_bcd_s day;
    rtw_bcd_s weekday;
    rtw_bcd_s hours;
    rtw_bcd_s minutes;
    rtw_bcd_s seconds;
  } rtw_time_s;

  typedef struct packed {
    rtw_bcd_s month;
    rtw_bcd_s day;
    rtw_bcd_s weekday;
    rtw_bcd_s hours;
    rtw_bcd_s minutes;
    rtw_bcd_s seconds;
  } rtw_alarm_s;

  typedef struct packed {
    logic       run;
    logic       rsvd;
    logic       wren;
    logic       sync;
    logic       half;
    logic       oe;
    logic [1:0] ptr;
  } rtw_clk_cfg_s;

  typedef struct packed {
    logic       en;
    logic       endless_repeat;
    logic [3:0] mask;
    logic [1:0] ptr;
  } rtw_al_cfg_s;

  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic [1:0] sel;
    logic       rsvd_lo;
  } rtw_pad_s;

  typedef struct packed {
    logic signed [16:0] count;
    logic [5:0]         sec_cnt;
    logic               half_tick;
    logic               sec_tick;
  } rtw_presc_s;

  typedef struct packed {
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_prev;
    logic        run_en;
    logic        wr_en;
    logic        out_en;
    logic [1:0]  tptr;
    logic [7:0]  cal;
    logic [1:0]  out_sel;
    rtw_al_cfg_s al_cfg;
    logic [7:0]  al_rpt;
    rtw_time_s   tm;
    rtw_alarm_s  al;
    logic        key1;
    logic        armed;
    logic        al_flag;
    logic        al_pulse;
    logic        wake;
    logic        pin;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
  } rtw_core_s;

  localparam rtw_al_cfg_s AL_CFG_RST = '0;
  localparam rtw_core_s   CORE_RST   = '0;

  function automatic logic [1:0] dec_ptr(input logic [1:0] p);
    dec_ptr = (p == PTR_MINSEC) ? PTR_MINSEC : 2'(p - 2'h1);
  endfunction

  function automatic logic [31:0] word(input logic [7:0] b);
    word = {24'h000000, b};
  endfunction

endpackage

// [rtw_prescaler.sv]
`timescale 1ns/1ps
module rtw_prescaler
  import rtw_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       osc_tick,
  input  wire logic       clear,
  input  wire logic [7:0] cal,
  output logic            half_tick,
  output logic            sec_tick,
  output logic            half_bit,
  output logic            near_roll
);

  rtw_presc_s state_ff;
  rtw_presc_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.half_tick = 1'b0;
    nxt_state.sec_tick = 1'b0;
    if (clear) begin
      nxt_state.count = '0;
      nxt_state.sec_cnt = '0;
    end else if (osc_tick) begin
      if (state_ff.count == PRESC_LAST) begin
        nxt_state.half_tick = 1'b1;
        nxt_state.sec_tick = 1'b1;
        nxt_state.count = '0;
        nxt_state.sec_cnt = 6'(state_ff.sec_cnt + SEC_STEP);
        if (state_ff.sec_cnt == SEC_LAST) begin
          nxt_state.sec_cnt = '0;
          // Starting ahead skips pulses, starting below zero waits for extra ones
          nxt_state.count = {{7{cal[7]}}, cal, 2'b00};
        end
      end else begin
        nxt_state.count = 17'(state_ff.count + PRESC_STEP);
        if (state_ff.count == HALF_LAST) begin
          nxt_state.half_tick = 1'b1;
        end
      end
    end
  end

  // No reset at all: only a seconds write restarts the fraction
  always_ff @(posedge hclk) begin
    state_ff <= nxt_state;
  end

  assign half_tick = state_ff.half_tick;
  assign sec_tick  = state_ff.sec_tick;
  assign half_bit  = (state_ff.count >= HALF_START);
  assign near_roll = (state_ff.count >= SYNC_START);

endmodule

// [test_rtw_core.sv]
`timescale 1ns/1ps
module test_rtw_core;
  import rtw_pkg::*;
  logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic              dev_rst, osc_pin, osc_en, clk_out, clk_out_oe, alarm_flag, wake;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  int                errors, cmp_count, cyc;
  logic [7:0]        rst_ofs [6];
  logic [3:0][7:0]   th, tl, ah, al, ahe, ale;

  assign hready = hreadyout;

  rtw_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dev_rst(dev_rst),
    .osc_pin(osc_pin), .clk_out(clk_out), .clk_out_oe(clk_out_oe),
    .alarm_flag(alarm_flag), .wake(wake));

  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end

  // Oscillator rising edge every two bus clocks: fastest rate the pin synchroniser can follow
  always @(posedge hclk) begin
    if (osc_en) osc_pin <= ~osc_pin;
    cyc <= cyc + 1;
    if (cyc == 110000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel   <= 1'h1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  // Status bits of the clock config are masked: they are unknown until the seconds write
  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp,
                    input logic [7:0] m = 8'hFF);
    bus(1'h0, a, 8'h00);
    chk(what, rd & {24'h000000, m}, {24'h000000, exp & m});
  endtask

  task automatic walk(input logic [7:0] co, input logic [7:0] cb, input logic [7:0] ho,
                      input logic rdm, input logic [3:0][7:0] hv, input logic [3:0][7:0] lv);
    wr(co, cb | 8'h03);
    for (int p = 3; p >= 0; p--) begin
      if (rdm) begin
        rc("win_lo", ho + 8'h04, lv[p]);
        rc("win_hi", ho, hv[p]);
      end else begin
        wr(ho + 8'h04, lv[p]);
        wr(ho, hv[p]);
      end
    end
    rc("win_hi_stick", ho, hv[0]);
    rc("win_ptr", co, cb, 8'hE7);
  endtask

  task automatic alarm(input logic [7:0] cfg, input logic [7:0] rpt, input logic pulse);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (wake !== 1'h1 && n < 40000);
    chk("wake", {31'h0, wake}, 32'h1);
    chk("flag_pin", {31'h0, alarm_flag}, 32'h1);
    rc("flag", OFS_STATUS, 8'h01);
    rc("alarm_cfg", OFS_AL_CFG, cfg);
    rc("repeat", OFS_AL_RPT, rpt);
    chk("pulse", {31'h0, clk_out}, {31'h0, pulse});
    wr(OFS_STATUS, 8'h01);
    rc("flag_clr", OFS_STATUS, 8'h00);
    chk("flag_pin_clr", {31'h0, alarm_flag}, 32'h0);
  endtask

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = '0;
    dev_rst = 1'h0;
    osc_pin = 1'h0;
    osc_en = 1'h0;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    rst_ofs = '{OFS_CLK_CFG, OFS_CAL, OFS_PAD_CFG, OFS_AL_CFG, OFS_AL_RPT, OFS_STATUS};
    th = 32'h00110345;
    tl = 32'h25170930;
    ah = 32'h99061205;
    al = 32'h88150930;
    ahe = 32'h00061205;
    ale = 32'h00150930;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    foreach (rst_ofs[i]) rc("reset_value", rst_ofs[i], 8'h00, 8'hE7);
    wr(OFS_CLK_CFG, 8'h24);
    rc("wren_locked", OFS_CLK_CFG, 8'h04, 8'hE7);
    wr(OFS_TWIN_LO, 8'h42);
    rc("time_locked", OFS_TWIN_LO, 8'h00);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CLK_CFG, 8'h24);
    // The enable is registered at the edge that ends the data phase
    @(posedge hclk);
    chk("oe", {31'h0, clk_out_oe}, 32'h1);
    wr(OFS_CAL, 8'hFC);
    rc("cal", OFS_CAL, 8'hFC);
    walk(OFS_CLK_CFG, 8'hA4, OFS_TWIN_HI, 1'h0, th, tl);
    osc_en <= 1'h1;
    walk(OFS_CLK_CFG, 8'hA4, OFS_TWIN_HI, 1'h1, th, tl);
    walk(OFS_AL_CFG, 8'h00, OFS_AWIN_HI, 1'h0, ah, al);
    walk(OFS_AL_CFG, 8'h00, OFS_AWIN_HI, 1'h1, ahe, ale);
    for (int m = 0; m <= 9; m++) begin
      wr(OFS_AL_CFG, 8'(m << 2));
      rc("mask", OFS_AL_CFG, 8'(m << 2));
    end
    wr(OFS_PAD_CFG, 8'h02);
    rc("pad", OFS_PAD_CFG, 8'h02);
    wr(OFS_PAD_CFG, 8'h00);
    rc("unmapped", 8'h3C, 8'h00);
    wr(OFS_AL_RPT, 8'h01);
    wr(OFS_AL_CFG, 8'h80);
    alarm(8'h80, 8'h00, 1'h1);
    wr(OFS_PAD_CFG, 8'h04);
    repeat (3) @(posedge hclk);
    chk("clk_out_off", {31'h0, clk_out}, 32'h0);
    wr(OFS_PAD_CFG, 8'h02);
    repeat (3) @(posedge hclk);
    chk("clk_out_sec", {31'h0, clk_out}, 32'h1);
    wr(OFS_PAD_CFG, 8'h00);
    // Minute mask: fires on the seconds tick only when both seconds digits match
    wr(OFS_AL_CFG, 8'h8C);
    alarm(8'h0C, 8'h00, 1'h0);
    wr(OFS_AL_CFG, 8'hC0);
    alarm(8'hC0, REPEAT_WRAP, 1'h1);
    dev_rst <= 1'h1;
    repeat (5) @(posedge hclk);
    dev_rst <= 1'h0;
    @(posedge hclk);
    rc("dev_rst_alarm", OFS_AL_CFG, 8'h00);
    rc("dev_rst_rpt", OFS_AL_RPT, REPEAT_WRAP);
    rc("dev_rst_cfg", OFS_CLK_CFG, 8'hA4, 8'hE7);
    tally_and_finish();
  end
endmodule
